// file: rtl/timer_pkg.sv
// constants, field layouts and state carrier of the timer block
package timer_pkg;

    // channel counts
    localparam int NUM_CMP = 2;
    localparam int NUM_CAP = 2;
    localparam int NUM_IN = NUM_CAP + 1;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_MASK = 8'h08;
    localparam logic [7:0] OFS_COUNT = 8'h0C;
    localparam logic [7:0] OFS_ACCUM = 8'h10;
    localparam logic [7:0] OFS_DUTY = 8'h14;
    localparam logic [7:0] OFS_CMP0 = 8'h18;
    localparam logic [7:0] OFS_CMP1 = 8'h1C;
    localparam logic [7:0] OFS_CAP0 = 8'h20;
    localparam logic [7:0] OFS_CAP1 = 8'h24;
    localparam logic [7:0] OFS_GPO = 8'h28;

    // control field positions
    localparam int CTRL_ACC_EN = 0;
    localparam int CTRL_ACC_GATED = 1;
    localparam int CTRL_ACC_TOF = 2;
    localparam int CTRL_ACC_POL = 3;
    localparam int CTRL_CMP_ACT = 4;
    localparam int CTRL_CAP_EDGE = 8;
    localparam int CTRL_PWM_EN = 12;
    localparam int CTRL_W = 13;

    // status and mask bit positions
    localparam int ST_ACC_IN = 0;
    localparam int ST_ACC_OVF = 1;
    localparam int ST_CMP = 2;
    localparam int ST_CAP = 4;
    localparam int ST_TOF = 6;
    localparam int ST_W = 7;

    // gpo register layout: enables low, values above
    localparam int GPO_VAL = 8;

    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 13'h0000;
    localparam logic [ST_W-1:0] MASK_RST = 7'h00;
    localparam logic [15:0] CMP_RST = 16'hFFFF;
    localparam logic [7:0] DUTY_RST = 8'h80;

    // timing: counter advances once per four phase clocks
    localparam int PRESC_DIV = 4;
    localparam logic [1:0] PRESC_LAST = 2'(PRESC_DIV - 1);
    localparam int MIN_PULSE_CLKS = 2;

    // output compare pin actions
    typedef enum logic [1:0] {
        act_none,
        act_toggle,
        act_clear,
        act_set
    } cmp_act_type;

    // complete block state
    typedef struct packed {
        logic [1:0] presc;
        logic [15:0] free_run_counter;
        logic [7:0] accum_counter;
        logic [7:0] pwm_counter;
        logic [7:0] pwm_duty;
        logic pwm_pin;
        logic [CTRL_W-1:0] ctrl;
        logic [ST_W-1:0] status;
        logic [ST_W-1:0] mask;
        logic [NUM_CMP-1:0][15:0] cmp_val;
        logic [NUM_CMP-1:0] cmp_pend;
        logic [NUM_CMP-1:0] cmp_pin;
        logic [NUM_CAP-1:0][15:0] cap_val;
        logic [NUM_CAP-1:0] gpo_oe;
        logic [NUM_CAP-1:0] gpo_val;
        logic [NUM_IN-1:0] sync1;
        logic [NUM_IN-1:0] sync2;
        logic [NUM_IN-1:0] sync3;
        logic [NUM_IN-1:0] filt;
    } state_type;

    // apb request bundle
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_type;

endpackage

// file: rtl/timer_pulse_accumulator_pwm.sv
// timer with free-running counter, pulse accumulator, compare, capture and pwm
// How it works
// - every timer input passes a two-stage synchroniser and then a digital filter before use.
// - the 16-bit free-running counter advances once every four phase clocks.
// - in event mode the leading edge bumps the accumulator and sets its input flag.
// - an accumulator wrap from all ones to zero sets the accumulator overflow flag.
// - in gated mode the input flag is set when the input falls back to inactive.
// - gated by counter overflow, the accumulator counts on 16-bit wraps while input is active.
// - in fast mode the pwm pin goes high when the pwm counter rolls from max to zero.
// - the pwm pin goes low when the pwm counter equals the duty value.
// - a compare match sets the compare flag first and changes the pin a cycle later.
// - a qualified capture edge latches the counter and sets the capture flag together.
// - a level driven on a capture pin as output still feeds the conditioner and captures.
`timescale 1ns/1ps
module timer_pulse_accumulator_pwm
    import timer_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_srst,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // timer pins
    input wire logic i_accum_input_pin,
    input wire logic [NUM_CAP-1:0] i_capture_pin,
    output logic [NUM_CAP-1:0] o_capture_pin,
    output logic [NUM_CAP-1:0] o_capture_pin_oe,
    output logic [NUM_CMP-1:0] o_compare_pin,
    output logic o_pwm_pin,
    // interrupt
    output logic o_irq
);

    state_type q;
    state_type d;
    apb_req_type req;

    logic tick;
    logic tof;
    logic acc_active;
    logic acc_lead;
    logic acc_trail;
    logic acc_inc;
    logic acc_wr;
    logic acc_ovf;
    logic pwm_set;
    logic rd_status;
    logic [NUM_IN-1:0] rise;
    logic [NUM_IN-1:0] fall;
    logic [NUM_CMP-1:0] cmp_hit;
    logic [NUM_CAP-1:0] cap_edge;
    logic [ST_W-1:0] set_vec;

    // offsets answered by this slave
    function automatic logic addr_mapped(input logic [7:0] a);
        unique case (a)
            OFS_CTRL, OFS_STATUS, OFS_MASK, OFS_COUNT, OFS_ACCUM, OFS_DUTY,
            OFS_CMP0, OFS_CMP1, OFS_CAP0, OFS_CAP1, OFS_GPO: addr_mapped = 1'b1;
            default: addr_mapped = 1'b0;
        endcase
    endfunction

    // request bundle
    assign req = '{psel: i_psel, penable: i_penable, pwrite: i_pwrite,
                   paddr: i_paddr, pwdata: i_pwdata};

    // zero wait states; unmapped offsets answer with an error
    assign o_pready = 1'b1;
    assign o_pslverr = req.psel && req.penable && !addr_mapped(req.paddr);

    // read mux; all sources are flops
    always_comb begin
        o_prdata = 32'h0000_0000;
        if (req.psel && !req.pwrite) begin
            unique case (req.paddr)
                OFS_CTRL: o_prdata = 32'(q.ctrl);
                OFS_STATUS: o_prdata = 32'(q.status);
                OFS_MASK: o_prdata = 32'(q.mask);
                OFS_COUNT: o_prdata = 32'(q.free_run_counter);
                OFS_ACCUM: o_prdata = 32'(q.accum_counter);
                OFS_DUTY: o_prdata = 32'(q.pwm_duty);
                OFS_CMP0: o_prdata = 32'(q.cmp_val[0]);
                OFS_CMP1: o_prdata = 32'(q.cmp_val[1]);
                OFS_CAP0: o_prdata = 32'(q.cap_val[0]);
                OFS_CAP1: o_prdata = 32'(q.cap_val[1]);
                OFS_GPO: o_prdata = {16'h0000, 6'h00, q.gpo_val, 6'h00, q.gpo_oe};
                default: o_prdata = 32'h0000_0000;
            endcase
        end
    end

    // next-state logic for the whole block
    always_comb begin
        logic [NUM_IN-1:0] src;
        logic [1:0] sel;
        cmp_act_type act;
        src = '0;
        sel = '0;
        act = act_none;
        d = q;

        // conditioner: gpo level loops back into the capture input
        src = {(q.gpo_oe & q.gpo_val) | (~q.gpo_oe & i_capture_pin), i_accum_input_pin};
        d.sync1 = src;
        d.sync2 = q.sync1;
        d.sync3 = q.sync2;
        // filter: a level is taken only once two samples agree, spikes die here
        for (int i = 0; i < NUM_IN; i++) begin
            if (q.sync2[i] == q.sync3[i]) begin
                d.filt[i] = q.sync3[i];
            end
        end
        rise = d.filt & ~q.filt;
        fall = ~d.filt & q.filt;

        // prescaler and free-running counter
        d.presc = q.presc + 2'h1;
        tick = (q.presc == PRESC_LAST);
        if (tick) begin
            d.free_run_counter = q.free_run_counter + 16'h0001;
        end
        tof = tick && (q.free_run_counter == 16'hFFFF);

        // pulse accumulator; polarity picks which edge leads
        acc_active = (q.filt[0] == q.ctrl[CTRL_ACC_POL]);
        acc_lead = q.ctrl[CTRL_ACC_EN] && !q.ctrl[CTRL_ACC_GATED] &&
                   (q.ctrl[CTRL_ACC_POL] ? rise[0] : fall[0]);
        acc_trail = q.ctrl[CTRL_ACC_EN] && q.ctrl[CTRL_ACC_GATED] &&
                    (q.ctrl[CTRL_ACC_POL] ? fall[0] : rise[0]);
        if (!q.ctrl[CTRL_ACC_EN]) begin
            acc_inc = 1'b0;
        end else if (!q.ctrl[CTRL_ACC_GATED]) begin
            acc_inc = acc_lead;
        end else if (q.ctrl[CTRL_ACC_TOF]) begin
            acc_inc = tof && acc_active;
        end else begin
            acc_inc = tick && acc_active;
        end
        acc_ovf = acc_inc && (q.accum_counter == 8'hFF);
        if (acc_inc) begin
            d.accum_counter = q.accum_counter + 8'h01;
        end

        // fast pwm; disabled channel parks low with counter cleared
        pwm_set = q.ctrl[CTRL_PWM_EN] && tick && (q.pwm_counter == 8'hFF);
        if (!q.ctrl[CTRL_PWM_EN]) begin
            d.pwm_counter = 8'h00;
            d.pwm_pin = 1'b0;
        end else begin
            if (tick) begin
                d.pwm_counter = q.pwm_counter + 8'h01;
            end
            if (pwm_set) begin
                d.pwm_pin = 1'b1;
            end else if (q.pwm_counter == q.pwm_duty) begin
                d.pwm_pin = 1'b0;
            end
        end

        // output compare: match checked on the cycle the counter takes a new value
        for (int k = 0; k < NUM_CMP; k++) begin
            cmp_hit[k] = (q.presc == 2'h0) && (q.free_run_counter == q.cmp_val[k]);
            d.cmp_pend[k] = cmp_hit[k];
            act = cmp_act_type'(q.ctrl[CTRL_CMP_ACT + 2*k +: 2]);
            if (q.cmp_pend[k]) begin
                unique case (act)
                    act_none: d.cmp_pin[k] = q.cmp_pin[k];
                    act_toggle: d.cmp_pin[k] = !q.cmp_pin[k];
                    act_clear: d.cmp_pin[k] = 1'b0;
                    act_set: d.cmp_pin[k] = 1'b1;
                endcase
            end
        end

        // input capture: 01 rising, 10 falling, 11 both
        for (int k = 0; k < NUM_CAP; k++) begin
            sel = q.ctrl[CTRL_CAP_EDGE + 2*k +: 2];
            cap_edge[k] = (sel[0] && rise[k+1]) || (sel[1] && fall[k+1]);
            if (cap_edge[k]) begin
                d.cap_val[k] = q.free_run_counter;
            end
        end

        // sticky status; read clears, a fresh event in the same cycle wins
        set_vec = '0;
        set_vec[ST_ACC_IN] = acc_lead || acc_trail;
        set_vec[ST_ACC_OVF] = acc_ovf;
        set_vec[ST_CMP +: NUM_CMP] = cmp_hit;
        set_vec[ST_CAP +: NUM_CAP] = cap_edge;
        set_vec[ST_TOF] = tof;
        rd_status = req.psel && req.penable && !req.pwrite && (req.paddr == OFS_STATUS);
        d.status = (rd_status ? '0 : q.status) | set_vec;

        // register writes take effect at the access-phase edge
        acc_wr = req.psel && req.penable && req.pwrite && (req.paddr == OFS_ACCUM);
        if (req.psel && req.penable && req.pwrite) begin
            unique case (req.paddr)
                OFS_CTRL: d.ctrl = req.pwdata[CTRL_W-1:0];
                OFS_MASK: d.mask = req.pwdata[ST_W-1:0];
                OFS_ACCUM: d.accum_counter = req.pwdata[7:0];
                OFS_DUTY: d.pwm_duty = req.pwdata[7:0];
                OFS_CMP0: d.cmp_val[0] = req.pwdata[15:0];
                OFS_CMP1: d.cmp_val[1] = req.pwdata[15:0];
                OFS_GPO: begin
                    d.gpo_oe = req.pwdata[NUM_CAP-1:0];
                    d.gpo_val = req.pwdata[GPO_VAL +: NUM_CAP];
                end
                default: d.ctrl = q.ctrl;
            endcase
        end
    end

    // state register
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            q <= '0;
            q.ctrl <= CTRL_RST;
            q.mask <= MASK_RST;
            q.pwm_duty <= DUTY_RST;
            q.cmp_val <= {NUM_CMP{CMP_RST}};
        end else begin
            q <= d;
        end
    end

    // pin outputs straight from flops; irq is a level formed from the status and mask flops
    assign o_capture_pin = q.gpo_val;
    assign o_capture_pin_oe = q.gpo_oe;
    assign o_compare_pin = q.cmp_pin;
    assign o_pwm_pin = q.pwm_pin;
    assign o_irq = |(q.status & q.mask);

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_srst);

    // filtered level equals both sync samples of the previous cycle
    property p_filter;
        !$stable(q.filt[0]) |-> ($past(q.sync2[0]) == q.filt[0]) && ($past(q.sync3[0]) == q.filt[0]);
    endproperty
    a_filter: assert property (p_filter) else $error("filter passed an unagreed level");

    // counter moves exactly on the fourth phase clock
    property p_count_rate;
        (q.presc == 2'h3) |=> (q.free_run_counter == $past(q.free_run_counter) + 16'h0001);
    endproperty
    a_count_rate: assert property (p_count_rate) else $error("counter missed its tick");

    property p_count_hold;
        (q.presc != 2'h3) |=> $stable(q.free_run_counter);
    endproperty
    a_count_hold: assert property (p_count_hold) else $error("counter moved off tick");

    // event mode leading edge sets the input flag and counts
    property p_event;
        (acc_lead && !acc_wr) |=> q.status[ST_ACC_IN] &&
            (q.accum_counter == $past(q.accum_counter) + 8'h01);
    endproperty
    a_event: assert property (p_event) else $error("event edge lost");

    property p_ovf;
        (acc_inc && q.accum_counter == 8'hFF) |=> q.status[ST_ACC_OVF];
    endproperty
    a_ovf: assert property (p_ovf) else $error("accumulator wrap without flag");

    property p_gated_flag;
        acc_trail |=> q.status[ST_ACC_IN];
    endproperty
    a_gated_flag: assert property (p_gated_flag) else $error("gate end without flag");

    // tof-gated accumulator changes only on a wrap while active
    property p_tof_gate;
        (q.ctrl[CTRL_ACC_EN] && q.ctrl[CTRL_ACC_GATED] && q.ctrl[CTRL_ACC_TOF] && !acc_wr)
            ##1 !$stable(q.accum_counter) |-> $past(tof) && $past(acc_active);
    endproperty
    a_tof_gate: assert property (p_tof_gate) else $error("gated count off overflow");

    property p_pwm_set;
        pwm_set |=> o_pwm_pin;
    endproperty
    a_pwm_set: assert property (p_pwm_set) else $error("pwm pin not set at rollover");

    property p_pwm_clr;
        (q.ctrl[CTRL_PWM_EN] && !pwm_set && q.pwm_counter == q.pwm_duty) |=> !o_pwm_pin;
    endproperty
    a_pwm_clr: assert property (p_pwm_clr) else $error("pwm pin not cleared at duty");

    // flag first, pin one cycle later
    property p_cmp_toggle;
        (cmp_hit[0] && q.ctrl[CTRL_CMP_ACT +: 2] == 2'h1 && !(req.psel && req.penable && req.pwrite))
            |=> (q.status[ST_CMP] && $stable(o_compare_pin[0])) ##1 !$stable(o_compare_pin[0]);
    endproperty
    a_cmp_toggle: assert property (p_cmp_toggle) else $error("compare order broken");

    property p_capture;
        cap_edge[0] |=> (q.cap_val[0] == $past(q.free_run_counter)) && q.status[ST_CAP];
    endproperty
    a_capture: assert property (p_capture) else $error("capture latch or flag missing");

    property p_gpo_loop;
        (q.gpo_oe[0] && $stable(q.gpo_val[0]) && $stable(q.gpo_oe[0]))[*4]
            |-> (q.filt[1] == q.gpo_val[0]);
    endproperty
    a_gpo_loop: assert property (p_gpo_loop) else $error("driven level not seen by input");

    property p_set_wins;
        (rd_status && |set_vec) |=> ((q.status & $past(set_vec)) == $past(set_vec));
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost to read clear");

    // flags move only on an event or a status read
    property p_status_hold;
        (!rd_status && set_vec == '0) |=> $stable(q.status);
    endproperty
    a_status_hold: assert property (p_status_hold) else $error("flag changed with no cause");

    // capture register only moves on a qualified edge
    property p_cap_hold;
        !cap_edge[0] |=> $stable(q.cap_val[0]);
    endproperty
    a_cap_hold: assert property (p_cap_hold) else $error("capture moved without edge");

    // disabled pwm keeps its pin parked low
    property p_pwm_off;
        !q.ctrl[CTRL_PWM_EN] |=> !o_pwm_pin;
    endproperty
    a_pwm_off: assert property (p_pwm_off) else $error("pwm pin high while disabled");

    // a disabled accumulator only changes by a register write
    property p_acc_off;
        (!q.ctrl[CTRL_ACC_EN] && !acc_wr) |=> $stable(q.accum_counter);
    endproperty
    a_acc_off: assert property (p_acc_off) else $error("accumulator counted while off");

    // main scenarios
    c_capture: cover property (cap_edge[0] ##1 rd_status);
    c_pwm_cycle: cover property (pwm_set ##[1:300] !o_pwm_pin);
    c_acc_ovf: cover property (acc_ovf);
    c_clear_race: cover property (rd_status && |set_vec);

endmodule

// file: tb/timer_pin_source.sv
// outside pin source driving the accumulator and capture inputs
`timescale 1ns/1ps
module timer_pin_source
    import timer_pkg::*;
(
    // clock
    input wire logic i_core_clk,
    // driven pins
    output logic o_accum_input_pin,
    output logic [NUM_CAP-1:0] o_capture_pin
);
    logic [NUM_IN-1:0] pins_q;

    // index 0 is the accumulator pin, captures above it
    assign o_accum_input_pin = pins_q[0];
    assign o_capture_pin = pins_q[NUM_IN-1:1];

    initial begin
        pins_q = '0;
    end

    // one pulse; short requests are stretched so the conditioner cannot miss them
    task automatic pulse(input int idx, input int hi_clks, input int lo_clks);
        @(posedge i_core_clk);
        pins_q[idx] <= 1'b1;
        repeat ((hi_clks < MIN_PULSE_CLKS) ? MIN_PULSE_CLKS : hi_clks) @(posedge i_core_clk);
        pins_q[idx] <= 1'b0;
        repeat ((lo_clks < MIN_PULSE_CLKS) ? MIN_PULSE_CLKS : lo_clks) @(posedge i_core_clk);
    endtask
endmodule

// file: tb/timer_pulse_accumulator_pwm_tb_top.sv
// self-checking bench for the timer block over apb and its pins
`timescale 1ns/1ps
module timer_pulse_accumulator_pwm_tb_top;
    import timer_pkg::*;

    logic i_core_clk;
    logic i_srst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic accum_pin;
    logic [NUM_CAP-1:0] cap_src;
    logic [NUM_CAP-1:0] cap_out;
    logic [NUM_CAP-1:0] cap_oe;
    logic [NUM_CAP-1:0] cap_pin;
    logic [NUM_CMP-1:0] cmp_pin;
    logic pwm_pin;
    logic irq;
    int n_fail;
    int check_count;
    logic [31:0] d;
    logic [31:0] c0;
    logic [31:0] c1;
    logic e;
    int n;

    // wire level: the block wins where it drives the pin
    assign cap_pin = (cap_oe & cap_out) | (~cap_oe & cap_src);

    timer_pulse_accumulator_pwm timer_pulse_accumulator_pwm_i (
        .i_core_clk(i_core_clk), .i_srst(i_srst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_accum_input_pin(accum_pin),
        .i_capture_pin(cap_pin), .o_capture_pin(cap_out), .o_capture_pin_oe(cap_oe),
        .o_compare_pin(cmp_pin), .o_pwm_pin(pwm_pin), .o_irq(irq));

    timer_pin_source timer_pin_source_i (
        .i_core_clk(i_core_clk), .o_accum_input_pin(accum_pin), .o_capture_pin(cap_src));

    always #2 i_core_clk = ~i_core_clk;

    // verdict and end of run
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int k;
        k = 0;
        @(posedge i_core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge i_core_clk);
        penable <= 1'b1;
        do begin
            @(posedge i_core_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        err = pslverr;
        if (k >= 50) begin
            n_fail++;
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] x;
        logic y;
        apb(1'b1, a, wd, x, y);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        logic y;
        apb(1'b0, a, 32'h00000000, v, y);
    endtask

    // watchdog well beyond the expected run length
    initial begin
        #200000;
        n_fail++;
        conclude();
    end

    initial begin
        i_core_clk = 1'b0;
        i_srst = 1'b1;
        {psel, penable, pwrite} = 3'b000;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        n_fail = 0;
        check_count = 0;
        repeat (6) @(posedge i_core_clk);
        i_srst <= 1'b0;
        // reset values and an unmapped place
        rd(OFS_CTRL, d); check(d, 32'h00000000);
        rd(OFS_MASK, d); check(d, 32'h00000000);
        rd(OFS_DUTY, d); check(d, 32'h00000080);
        rd(OFS_CMP1, d); check(d, 32'h0000FFFF);
        apb(1'b0, 8'h3C, 32'h00000000, d, e);
        check({d[30:0], e}, 32'h00000001);
        // counter rate: 40 clocks apart gives 10 steps
        rd(OFS_COUNT, c0);
        repeat (37) @(posedge i_core_clk);
        rd(OFS_COUNT, c1);
        check(c1 - c0, 32'h0000000A);
        // capture on a rising pin edge, masked so no interrupt
        wr(OFS_CTRL, 32'h00000100);
        rd(OFS_COUNT, c0);
        timer_pin_source_i.pulse(1, 8, 8);
        check({31'h0, irq}, 32'h00000000);
        rd(OFS_STATUS, d); check(d, 32'h00000010);
        rd(OFS_CAP0, c1);
        check({31'h0, (c1 >= c0) && (c1 <= c0 + 32'h8)}, 32'h00000001);
        // level driven as output still captures
        wr(OFS_CTRL, 32'h00000400);
        wr(OFS_GPO, 32'h00000303);
        repeat (8) @(posedge i_core_clk);
        check({30'h0, cap_oe}, 32'h00000003);
        check({30'h0, cap_out}, 32'h00000003);
        rd(OFS_STATUS, d); check(d, 32'h00000020);
        wr(OFS_GPO, 32'h00000000);
        // event mode: two edges from FE wrap to zero
        wr(OFS_CTRL, 32'h00000009);
        wr(OFS_ACCUM, 32'h000000FE);
        timer_pin_source_i.pulse(0, 4, 4);
        timer_pin_source_i.pulse(0, 4, 4);
        rd(OFS_ACCUM, d); check(d, 32'h00000000);
        rd(OFS_STATUS, d); check(d, 32'h00000003);
        rd(OFS_STATUS, d); check(d, 32'h00000000);
        // gated mode: flag only once the input falls back
        wr(OFS_ACCUM, 32'h00000000);
        wr(OFS_CTRL, 32'h0000000B);
        fork
            timer_pin_source_i.pulse(0, 60, 8);
            begin
                repeat (30) @(posedge i_core_clk);
                rd(OFS_STATUS, d); check(d, 32'h00000000);
            end
        join
        rd(OFS_STATUS, d); check(d, 32'h00000001);
        rd(OFS_ACCUM, d);
        check({31'h0, (d >= 32'hD) && (d <= 32'h11)}, 32'h00000001);
        // overflow-clocked gating: no 16-bit wrap happens, so no count
        wr(OFS_ACCUM, 32'h00000000);
        wr(OFS_CTRL, 32'h0000000F);
        timer_pin_source_i.pulse(0, 40, 8);
        rd(OFS_ACCUM, d); check(d, 32'h00000000);
        rd(OFS_STATUS, d); check(d, 32'h00000001);
        // compare toggle: flag (seen on irq) already up when the pin moves
        rd(OFS_COUNT, c0);
        wr(OFS_CMP0, c0 + 32'h20);
        wr(OFS_MASK, 32'h00000004);
        wr(OFS_CTRL, 32'h00000010);
        n = 0;
        while (cmp_pin[0] !== 1'b1 && n < 300) begin
            @(posedge i_core_clk);
            n++;
        end
        check({31'h0, cmp_pin[0]}, 32'h00000001);
        check({31'h0, irq}, 32'h00000001);
        rd(OFS_STATUS, d); check(d, 32'h00000004);
        @(posedge i_core_clk);
        check({31'h0, irq}, 32'h00000000);
        wr(OFS_MASK, 32'h00000000);
        // fast pwm with duty 4: clear is registered, so high 4*duty+1 clocks of 1024
        wr(OFS_DUTY, 32'h00000004);
        wr(OFS_CTRL, 32'h00001000);
        n = 0;
        while (pwm_pin !== 1'b1 && n < 1100) begin
            @(posedge i_core_clk);
            n++;
        end
        n = 0;
        while (pwm_pin === 1'b1 && n < 1100) begin
            @(posedge i_core_clk);
            n++;
        end
        check(32'(n), 32'h00000011);
        while (pwm_pin !== 1'b1 && n < 1100) begin
            @(posedge i_core_clk);
            n++;
        end
        check(32'(n), 32'h00000400);
        conclude();
    end
endmodule
